// >>> src/feat_cmd_map.vh
// Register offsets, field positions, codes and timing for the command unit
`ifndef FEAT_CMD_MAP_VH
`define FEAT_CMD_MAP_VH

// Register byte offsets
`define OFS_CMD        8'h00
`define OFS_FEAT       8'h04
`define OFS_SECCNT     8'h08
`define OFS_STATUS     8'h0C
`define OFS_CONFIG     8'h10
`define OFS_MODES      8'h14

// Status fields
`define ST_BUSY        0
`define ST_SLEEP       1
`define ST_ABORT       2
`define ST_IRQ         3
`define ST_FLUSH       4

// Config fields
`define CF_BYTE        0
`define CF_WCACHE      1
`define CF_APM         2
`define CF_EXTPWR      3
`define CF_PL1         4
`define CF_ECC4        5
`define CF_LOOKAHEAD   6
`define CF_KEEPDEF     7
`define CF_MULT        8

// Modes fields
`define MD_PIO_LSB     0
`define MD_DMA_LSB     4
`define MD_MULT_LSB    8
`define MD_CAP_LSB     16

// Command codes
`define CMD_SETFEAT    8'hEF
`define CMD_SETMULT    8'hC6
`define CMD_SLEEP_A    8'h99
`define CMD_SLEEP_B    8'hE6

// Subcommand codes
`define SF_BYTE_ON     8'h01
`define SF_BYTE_OFF    8'h81
`define SF_WC_ON       8'h02
`define SF_WC_OFF      8'h82
`define SF_XFER_MODE   8'h03
`define SF_APM_ON      8'h05
`define SF_APM_OFF     8'h85
`define SF_EXT_ON      8'h09
`define SF_EXT_OFF     8'h89
`define SF_PL1_ON      8'h0A
`define SF_PL1_OFF     8'h8A
`define SF_ECC_VEND    8'h44
`define SF_ECC_4       8'hBB
`define SF_LA_OFF      8'h55
`define SF_LA_ON       8'hAA
`define SF_KEEP_ON     8'h66
`define SF_KEEP_OFF    8'hCC
`define SF_NOP_A       8'h69
`define SF_NOP_B       8'h96
`define SF_NOP_C       8'h97
`define SF_CUR_CAP     8'h9A

// Transfer mode types (upper 5 bits of sector count)
`define XT_PIO_DEF     5'h00
`define XT_PIO_FC      5'h01
`define XT_MWDMA       5'h04
`define PIO_MAX        3'h4
`define DMA_MAX        3'h2

// Largest supported block count (power of two)
`define MULT_MAX       8'h10

// Reset values
`define RST_WCACHE     1'b0
`define RST_LOOKAHEAD  1'b1
`define RST_PIO        3'h0
`define RST_DMA        3'h0
`define RST_CAP        8'h00

// Idle timer
`define IDLE_TIME_NS   5000000
`define CLK_PERIOD_NS  10

`endif

// >>> src/feature_power_unit.v
// Set-features, set-multiple and sleep command execution with AHB-Lite registers
`timescale 1ns/100ps
`include "feat_cmd_map.vh"
module feature_power_unit #(
  parameter IDLE_CYCLES = `IDLE_TIME_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Card side
  input  wire        soft_reset,
  input  wire        data_reg_access,
  input  wire        flush_done,
  output wire        flush_req,
  output wire        wide_transfer_indicator,
  output wire        byte_lanes_only,
  output wire        sleep_mode,
  output wire        host_irq
);

  // FSM states
  localparam [1:0] S_IDLE  = 2'h0;
  localparam [1:0] S_EXEC  = 2'h1;
  localparam [1:0] S_FLUSH = 2'h2;
  localparam [1:0] S_DONE  = 2'h3;
  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  reg        wr_pend_ff;
  reg  [7:0] waddr_ff;
  wire       acc, rd_acc;
  assign acc    = hsel && hready && htrans[1];
  assign rd_acc = acc && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      waddr_ff   <= 8'h00;
    end else begin
      wr_pend_ff <= acc && hwrite;
      waddr_ff   <= haddr[7:0];
    end
  end

  // Write strobes in the data phase
  wire wr_cmd, wr_feat, wr_cnt, wr_stat;
  assign wr_cmd  = wr_pend_ff && (waddr_ff == `OFS_CMD);
  assign wr_feat = wr_pend_ff && (waddr_ff == `OFS_FEAT);
  assign wr_cnt  = wr_pend_ff && (waddr_ff == `OFS_SECCNT);
  assign wr_stat = wr_pend_ff && (waddr_ff == `OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  reg  [1:0] state_ff, nxt_state;
  reg  [7:0] cmd_ff, feat_ff, cnt_ff, mult_cnt_ff, cap_ff;
  reg  [7:0] nxt_cmd, nxt_feat, nxt_cnt, nxt_mult_cnt, nxt_cap;
  reg  [2:0] pio_ff, dma_ff, nxt_pio, nxt_dma;
  reg        sleep_ff, abort_ff, irq_ff, flush_ff, byte_ff, wcache_ff;
  reg        nxt_sleep, nxt_abort, nxt_irq, nxt_flush, nxt_byte, nxt_wcache;
  reg        apm_ff, extpwr_ff, pl1_ff, ecc4_ff, look_ff, keep_ff, mult_en_ff;
  reg        nxt_apm, nxt_extpwr, nxt_pl1, nxt_ecc4, nxt_look, nxt_keep, nxt_mult_en;
  wire       busy, idle_expire, cmd_start, cnt_pow2;

  assign busy      = (state_ff != S_IDLE);
  assign cmd_start = wr_cmd && !busy;

  // Block count valid: nonzero power of two up to the maximum
  assign cnt_pow2 = (cnt_ff != 8'h00) && ((cnt_ff & (cnt_ff - 8'h01)) == 8'h00)
                    && (cnt_ff <= `MULT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer and settings
  always @* begin
    nxt_state    = state_ff;
    nxt_cmd      = cmd_ff;
    nxt_feat     = feat_ff;
    nxt_cnt      = cnt_ff;
    nxt_sleep    = sleep_ff;
    nxt_abort    = abort_ff;
    nxt_irq      = irq_ff;
    nxt_flush    = flush_ff;
    nxt_byte     = byte_ff;
    nxt_wcache   = wcache_ff;
    nxt_apm      = apm_ff;
    nxt_extpwr   = extpwr_ff;
    nxt_pl1      = pl1_ff;
    nxt_ecc4     = ecc4_ff;
    nxt_look     = look_ff;
    nxt_keep     = keep_ff;
    nxt_mult_en  = mult_en_ff;
    nxt_mult_cnt = mult_cnt_ff;
    nxt_pio      = pio_ff;
    nxt_dma      = dma_ff;
    nxt_cap      = cap_ff;
    // Task-file writes only while not busy
    if (wr_feat && !busy) begin
      nxt_feat = hwdata[7:0];
    end
    if (wr_cnt && !busy) begin
      nxt_cnt = hwdata[7:0];
    end
    // Software clears the interrupt by writing one
    if (wr_stat && hwdata[`ST_IRQ]) begin
      nxt_irq = 1'b0;
    end
    case (state_ff)
      S_IDLE: begin
        if (cmd_start) begin
          nxt_cmd   = hwdata[7:0];
          nxt_sleep = 1'b0;
          nxt_abort = 1'b0;
          nxt_irq   = 1'b0;
          nxt_state = S_EXEC;
        end else if (idle_expire) begin
          nxt_sleep = 1'b1;
        end
      end
      S_EXEC: begin
        nxt_state = S_DONE;
        case (cmd_ff)
          `CMD_SETFEAT: begin
            case (feat_ff)
              `SF_BYTE_ON:   nxt_byte = 1'b1;
              `SF_BYTE_OFF:  nxt_byte = 1'b0;
              `SF_WC_ON:     nxt_wcache = 1'b1;
              `SF_WC_OFF: begin
                nxt_wcache = 1'b0;
                nxt_flush  = 1'b1;
                nxt_state  = S_FLUSH;
              end
              `SF_XFER_MODE: begin
                // One mode of each kind is always held
                if ((cnt_ff[7:3] == `XT_PIO_DEF) ||
                    (cnt_ff[7:3] == `XT_PIO_FC)) begin
                  if (cnt_ff[2:0] <= `PIO_MAX) begin
                    nxt_pio = cnt_ff[2:0];
                  end else begin
                    nxt_abort = 1'b1;
                  end
                end else if ((cnt_ff[7:3] == `XT_MWDMA) &&
                             (cnt_ff[2:0] <= `DMA_MAX)) begin
                  nxt_dma = cnt_ff[2:0];
                end else begin
                  nxt_abort = 1'b1;
                end
              end
              `SF_APM_ON:    nxt_apm = 1'b1;
              `SF_APM_OFF:   nxt_apm = 1'b0;
              `SF_EXT_ON:    nxt_extpwr = 1'b1;
              `SF_EXT_OFF:   nxt_extpwr = 1'b0;
              `SF_PL1_ON:    nxt_pl1 = 1'b1;
              `SF_PL1_OFF:   nxt_pl1 = 1'b0;
              `SF_ECC_VEND:  nxt_ecc4 = 1'b0;
              `SF_ECC_4:     nxt_ecc4 = 1'b1;
              `SF_LA_OFF:    nxt_look = 1'b0;
              `SF_LA_ON:     nxt_look = 1'b1;
              `SF_KEEP_ON:   nxt_keep = 1'b1;
              `SF_KEEP_OFF:  nxt_keep = 1'b0;
              `SF_NOP_A:     nxt_abort = 1'b0;
              `SF_NOP_B:     nxt_abort = 1'b0;
              `SF_NOP_C:     nxt_abort = 1'b0;
              `SF_CUR_CAP:   nxt_cap = cnt_ff;
              default:       nxt_abort = 1'b1;
            endcase
          end
          `CMD_SETMULT: begin
            if (cnt_ff == 8'h00) begin
              nxt_mult_en = 1'b0;
            end else if (cnt_pow2) begin
              nxt_mult_en  = 1'b1;
              nxt_mult_cnt = cnt_ff;
            end else begin
              nxt_mult_en = 1'b0;
              nxt_abort   = 1'b1;
            end
          end
          `CMD_SLEEP_A: nxt_sleep = 1'b1;
          `CMD_SLEEP_B: nxt_sleep = 1'b1;
          default:      nxt_sleep = 1'b0;
        endcase
      end
      S_FLUSH: begin
        // Completion held back until the flush ends
        if (flush_done) begin
          nxt_flush = 1'b0;
          nxt_state = S_DONE;
        end
      end
      S_DONE: begin
        nxt_irq   = 1'b1;
        nxt_state = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
    // Soft reset: abandon command, restore defaults unless kept
    if (soft_reset) begin
      nxt_state = S_IDLE;
      nxt_sleep = 1'b0;
      nxt_flush = 1'b0;
      nxt_irq   = 1'b0;
      if (!keep_ff) begin
        nxt_byte     = 1'b0;
        nxt_wcache   = `RST_WCACHE;
        nxt_apm      = 1'b0;
        nxt_extpwr   = 1'b0;
        nxt_pl1      = 1'b0;
        nxt_ecc4     = 1'b0;
        nxt_look     = `RST_LOOKAHEAD;
        nxt_mult_en  = 1'b0;
        nxt_mult_cnt = 8'h00;
        nxt_pio      = `RST_PIO;
        nxt_dma      = `RST_DMA;
        nxt_cap      = `RST_CAP;
      end
    end
  end

  // Power-on and hardware reset defaults
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff    <= S_IDLE;
      cmd_ff      <= 8'h00;
      feat_ff     <= 8'h00;
      cnt_ff      <= 8'h00;
      sleep_ff    <= 1'b0;
      abort_ff    <= 1'b0;
      irq_ff      <= 1'b0;
      flush_ff    <= 1'b0;
      byte_ff     <= 1'b0;
      wcache_ff   <= `RST_WCACHE;
      apm_ff      <= 1'b0;
      extpwr_ff   <= 1'b0;
      pl1_ff      <= 1'b0;
      ecc4_ff     <= 1'b0;
      look_ff     <= `RST_LOOKAHEAD;
      keep_ff     <= 1'b0;
      mult_en_ff  <= 1'b0;
      mult_cnt_ff <= 8'h00;
      pio_ff      <= `RST_PIO;
      dma_ff      <= `RST_DMA;
      cap_ff      <= `RST_CAP;
    end else begin
      state_ff    <= nxt_state;
      cmd_ff      <= nxt_cmd;
      feat_ff     <= nxt_feat;
      cnt_ff      <= nxt_cnt;
      sleep_ff    <= nxt_sleep;
      abort_ff    <= nxt_abort;
      irq_ff      <= nxt_irq;
      flush_ff    <= nxt_flush;
      byte_ff     <= nxt_byte;
      wcache_ff   <= nxt_wcache;
      apm_ff      <= nxt_apm;
      extpwr_ff   <= nxt_extpwr;
      pl1_ff      <= nxt_pl1;
      ecc4_ff     <= nxt_ecc4;
      look_ff     <= nxt_look;
      keep_ff     <= nxt_keep;
      mult_en_ff  <= nxt_mult_en;
      mult_cnt_ff <= nxt_mult_cnt;
      pio_ff      <= nxt_pio;
      dma_ff      <= nxt_dma;
      cap_ff      <= nxt_cap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle timer, runs only while awake and not busy
  idle_sleep_timer #(
    .CYCLES (IDLE_CYCLES)
  ) u_idle (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (!busy && !sleep_ff),
    .restart (wr_pend_ff || soft_reset),
    .expire  (idle_expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Card-side outputs
  assign wide_transfer_indicator = data_reg_access && !byte_ff;
  assign byte_lanes_only = byte_ff;
  assign flush_req       = flush_ff;
  assign sleep_mode      = sleep_ff;
  assign host_irq        = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered in the address phase
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h00000000;
    case (haddr[7:0])
      `OFS_CMD:    rd_word[7:0] = cmd_ff;
      `OFS_FEAT:   rd_word[7:0] = feat_ff;
      `OFS_SECCNT: rd_word[7:0] = cnt_ff;
      `OFS_STATUS: begin
        rd_word[`ST_BUSY]  = busy;
        rd_word[`ST_SLEEP] = sleep_ff;
        rd_word[`ST_ABORT] = abort_ff;
        rd_word[`ST_IRQ]   = irq_ff;
        rd_word[`ST_FLUSH] = flush_ff;
      end
      `OFS_CONFIG: begin
        rd_word[`CF_BYTE]      = byte_ff;
        rd_word[`CF_WCACHE]    = wcache_ff;
        rd_word[`CF_APM]       = apm_ff;
        rd_word[`CF_EXTPWR]    = extpwr_ff;
        rd_word[`CF_PL1]       = pl1_ff;
        rd_word[`CF_ECC4]      = ecc4_ff;
        rd_word[`CF_LOOKAHEAD] = look_ff;
        rd_word[`CF_KEEPDEF]   = keep_ff;
        rd_word[`CF_MULT]      = mult_en_ff;
      end
      `OFS_MODES: begin
        rd_word[`MD_PIO_LSB +: 3]  = pio_ff;
        rd_word[`MD_DMA_LSB +: 3]  = dma_ff;
        rd_word[`MD_MULT_LSB +: 8] = mult_cnt_ff;
        rd_word[`MD_CAP_LSB +: 8]  = cap_ff;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_acc) begin
      hrdata <= rd_word;
    end
  end

endmodule // feature_power_unit

// >>> src/idle_sleep_timer.v
// Idle up-counter that pulses when the card has been idle long enough
`timescale 1ns/100ps
module idle_sleep_timer #(
  parameter CYCLES = 500000
) (
  // Clock and reset
  input  wire hclk,
  input  wire hresetn,
  // Control
  input  wire run,
  input  wire restart,
  // Result
  output wire expire
);

  // Cut the count to the counter width on purpose
  localparam integer LAST_I = CYCLES - 1;
  localparam [19:0]  LAST   = LAST_I[19:0];

  reg  [19:0] cnt_ff;
  reg  [19:0] nxt_cnt;

  // Count idle cycles, restart on activity
  always @* begin
    nxt_cnt = cnt_ff;
    if (restart || !run) begin
      nxt_cnt = 20'h00000;
    end else if (cnt_ff != LAST) begin
      nxt_cnt = cnt_ff + 20'h00001;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 20'h00000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // One pulse one count before the end while running
  assign expire = run && !restart && (cnt_ff == LAST - 20'h00001);

endmodule // idle_sleep_timer

// >>> testbench/ata_feature_power_command_unit_bench.sv
// Register level tests of the feature and power command unit
`timescale 1ns/100ps
`include "feat_cmd_map.vh"
module ata_feature_power_command_unit_bench;
  localparam IDLE = 2000;
  reg         hclk, hresetn, hwrite, soft_reset, data_reg_access;
  reg  [31:0] haddr, hwdata, val;
  reg  [1:0]  htrans;
  reg  [7:0]  flush_delay;
  wire        hreadyout, hresp, flush_req, flush_done, wide_transfer_indicator;
  wire        byte_lanes_only, sleep_mode, host_irq;
  wire [31:0] hrdata;
  integer     n_mismatch, total_checks;

  feature_power_unit #(.IDLE_CYCLES(IDLE)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .soft_reset(soft_reset),
    .data_reg_access(data_reg_access), .flush_done(flush_done), .flush_req(flush_req),
    .wide_transfer_indicator(wide_transfer_indicator),
    .byte_lanes_only(byte_lanes_only), .sleep_mode(sleep_mode), .host_irq(host_irq));
  flush_responder u_far (.hclk(hclk), .hresetn(hresetn), .flush_req(flush_req),
    .delay(flush_delay), .flush_done(flush_done));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #500000;
    n_mismatch = n_mismatch + 1;
    end_sim;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus and check tasks
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        $display("unexpected %s expected %h seen %h", nm, exp, got);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask
  task bus(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      val = hrdata;
    end
  endtask
  task wait_done;
    integer n;
    begin
      n = 0;
      val = 32'h1;
      while (val[0] !== 1'b0 && n < 300) begin
        bus(1'b0, `OFS_STATUS, 32'h0);
        n = n + 1;
      end
    end
  endtask
  task issue(input [7:0] code, input [7:0] sub, input [7:0] cnt);
    begin
      bus(1'b1, `OFS_FEAT, {24'h0, sub});
      bus(1'b1, `OFS_SECCNT, {24'h0, cnt});
      bus(1'b1, `OFS_CMD, {24'h0, code});
    end
  endtask
  task step(input [7:0] code, input [7:0] sub, input [7:0] cnt, input [31:0] cfg,
            input [7:0] st);
    begin
      issue(code, sub, cnt);
      wait_done;
      chk("status", {24'h0, st}, val);
      bus(1'b0, `OFS_CONFIG, 32'h0);
      chk("config", cfg, val);
    end
  endtask
  task rd_chk(input string nm, input [7:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, exp, val);
    end
  endtask
  task pulse_soft;
    begin
      @(posedge hclk) soft_reset <= 1'b1;
      @(posedge hclk) soft_reset <= 1'b0;
      @(posedge hclk);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    hresetn = 1'b0;
    hwrite = 1'b0;
    soft_reset = 1'b0;
    data_reg_access = 1'b1;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    flush_delay = 8'h1E;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("status", `OFS_STATUS, 32'h0);
    rd_chk("config", `OFS_CONFIG, 32'h40);
    rd_chk("modes", `OFS_MODES, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    $display("reset values done");
    step(8'hEF, 8'h01, 8'h00, 32'h41, 8'h08);
    chk("lanes", 1, byte_lanes_only);
    chk("wide", 0, wide_transfer_indicator);
    step(8'hEF, 8'h81, 8'h00, 32'h40, 8'h08);
    chk("wide", 1, wide_transfer_indicator);
    @(posedge hclk) data_reg_access <= 1'b0;
    @(posedge hclk);
    chk("wide other", 0, wide_transfer_indicator);
    data_reg_access <= 1'b1;
    step(8'hEF, 8'h02, 8'h00, 32'h42, 8'h08);
    step(8'hEF, 8'h05, 8'h00, 32'h46, 8'h08);
    step(8'hEF, 8'h85, 8'h00, 32'h42, 8'h08);
    step(8'hEF, 8'h09, 8'h00, 32'h4A, 8'h08);
    step(8'hEF, 8'h89, 8'h00, 32'h42, 8'h08);
    step(8'hEF, 8'h0A, 8'h00, 32'h52, 8'h08);
    step(8'hEF, 8'h8A, 8'h00, 32'h42, 8'h08);
    step(8'hEF, 8'hBB, 8'h00, 32'h62, 8'h08);
    step(8'hEF, 8'h44, 8'h00, 32'h42, 8'h08);
    step(8'hEF, 8'h55, 8'h00, 32'h02, 8'h08);
    step(8'hEF, 8'hAA, 8'h00, 32'h42, 8'h08);
    step(8'hEF, 8'h69, 8'h00, 32'h42, 8'h08);
    step(8'hEF, 8'h96, 8'h00, 32'h42, 8'h08);
    step(8'hEF, 8'h97, 8'h00, 32'h42, 8'h08);
    step(8'hEF, 8'h7F, 8'h00, 32'h42, 8'h0C);
    $display("subcommand table done");
    issue(8'hEF, 8'h82, 8'h00);
    repeat (5) @(posedge hclk);
    rd_chk("flushing", `OFS_STATUS, 32'h11);
    wait_done;
    chk("flushed", 32'h08, val);
    rd_chk("config", `OFS_CONFIG, 32'h40);
    $display("cache flush done");
    step(8'hEF, 8'h03, 8'h0C, 32'h40, 8'h08);
    rd_chk("modes", `OFS_MODES, 32'h04);
    step(8'hEF, 8'h03, 8'h22, 32'h40, 8'h08);
    rd_chk("modes", `OFS_MODES, 32'h24);
    step(8'hEF, 8'h03, 8'h0D, 32'h40, 8'h0C);
    step(8'hEF, 8'h03, 8'h42, 32'h40, 8'h0C);
    step(8'hEF, 8'h03, 8'h03, 32'h40, 8'h08);
    rd_chk("modes", `OFS_MODES, 32'h23);
    step(8'hEF, 8'h9A, 8'h5A, 32'h40, 8'h08);
    rd_chk("modes", `OFS_MODES, 32'h5A0023);
    $display("transfer modes done");
    step(8'hC6, 8'h00, 8'h08, 32'h140, 8'h08);
    rd_chk("modes", `OFS_MODES, 32'h5A0823);
    step(8'hC6, 8'h00, 8'h03, 32'h40, 8'h0C);
    step(8'hC6, 8'h00, 8'h10, 32'h140, 8'h08);
    step(8'hC6, 8'h00, 8'h00, 32'h40, 8'h08);
    $display("block count done");
    step(8'hEF, 8'h01, 8'h00, 32'h41, 8'h08);
    pulse_soft;
    rd_chk("config", `OFS_CONFIG, 32'h40);
    rd_chk("modes", `OFS_MODES, 32'h0);
    step(8'hEF, 8'h66, 8'h00, 32'hC0, 8'h08);
    step(8'hEF, 8'h01, 8'h00, 32'hC1, 8'h08);
    step(8'hC6, 8'h00, 8'h04, 32'h1C1, 8'h08);
    pulse_soft;
    rd_chk("config", `OFS_CONFIG, 32'h1C1);
    step(8'hEF, 8'hCC, 8'h00, 32'h141, 8'h08);
    $display("soft reset done");
    step(8'h99, 8'h00, 8'h00, 32'h141, 8'h0A);
    chk("sleep", 1, sleep_mode);
    bus(1'b1, `OFS_STATUS, 32'h08);
    @(posedge hclk);
    chk("irq", 0, host_irq);
    step(8'hE5, 8'h00, 8'h00, 32'h141, 8'h08);
    chk("sleep", 0, sleep_mode);
    step(8'hE6, 8'h00, 8'h00, 32'h141, 8'h0A);
    step(8'hE5, 8'h00, 8'h00, 32'h141, 8'h08);
    repeat (IDLE + 50) @(posedge hclk);
    chk("idle sleep", 1, sleep_mode);
    $display("sleep done");
    end_sim;
  end
endmodule // ata_feature_power_command_unit_bench

// >>> testbench/flush_responder.sv
// Non-volatile store model answering cache flush requests after a set delay
`timescale 1ns/100ps
module flush_responder (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Flush handshake
  input  wire       flush_req,
  input  wire [7:0] delay,
  output reg        flush_done
);
  reg [7:0] cnt_ff;

  // Count flush cycles, pulse done once, then drop the line again
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff     <= 8'h00;
      flush_done <= 1'b0;
    end else if (flush_req && !flush_done && cnt_ff == delay) begin
      flush_done <= 1'b1;
      cnt_ff     <= 8'h00;
    end else begin
      flush_done <= 1'b0;
      cnt_ff     <= (flush_req && !flush_done) ? cnt_ff + 8'h01 : 8'h00;
    end
  end
endmodule // flush_responder

// >>> testbench/fpu_checker_sva.sv
// Concurrent checks on the command unit ports
`timescale 1ns/100ps
module fpu_checker #(
  parameter IDLE_CYCLES = 20
) (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        soft_reset,
  input wire        data_reg_access,
  input wire        flush_done,
  input wire        flush_req,
  input wire        wide_transfer_indicator,
  input wire        byte_lanes_only,
  input wire        sleep_mode,
  input wire        host_irq
);
  reg        cmd_ph_ff;
  reg [19:0] idle_ff;
  wire       sleep_cmd = cmd_ph_ff && !soft_reset &&
                         (hwdata[7:0] == 8'h99 || hwdata[7:0] == 8'hE6);

  // Command register write in address phase, data follows next cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cmd_ph_ff <= 1'b0;
    else cmd_ph_ff <= hsel & hready & htrans[1] & hwrite & (haddr[7:0] == 8'h00);
  end

  // Quiet cycles with the card awake and no flush under way
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) idle_ff <= 20'h00000;
    else if (htrans[1] | soft_reset | sleep_mode | flush_req) idle_ff <= 20'h00000;
    else if (idle_ff != 20'hFFFFF) idle_ff <= idle_ff + 20'h00001;
  end

  ready_const_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp) else $error("bus answer not zero wait OKAY");
  wide_ind_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wide_transfer_indicator == (data_reg_access && !byte_lanes_only))
    else $error("wide indicator wrong for lane mode");
  flush_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    flush_req && !flush_done |=> flush_req) else $error("flush request dropped early");
  flush_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    flush_req && flush_done |-> ##[1:2] !flush_req) else $error("flush request stuck");
  irq_after_flush_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(host_irq) |-> !flush_req) else $error("completion before flush end");
  sleep_enter_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_cmd |=> ##[0:3] sleep_mode) else $error("sleep command did not sleep");
  sleep_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_cmd |=> ##[0:3] host_irq) else $error("sleep command no interrupt");
  wake_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_ph_ff && !soft_reset |=> ##[0:1] !sleep_mode) else $error("command did not wake");
  idle_sleep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    idle_ff == IDLE_CYCLES + 8 |-> sleep_mode) else $error("idle timer did not sleep");
endmodule // fpu_checker

bind feature_power_unit fpu_checker #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .soft_reset(soft_reset), .data_reg_access(data_reg_access),
  .flush_done(flush_done), .flush_req(flush_req),
  .wide_transfer_indicator(wide_transfer_indicator),
  .byte_lanes_only(byte_lanes_only), .sleep_mode(sleep_mode), .host_irq(host_irq));
